// ---- hdl/tpdo_cfg_pkg.sv ----
// Purpose: Shared constants for the transmit PDO configuration block
// Assumes: Word-indexed register map, one 32-bit word per entry
// Notes:   Byte address of an entry is four times its index
package tpdo_cfg_pkg;
    // Clock and time units
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned MS_PER_SEC = 1000;
    localparam int unsigned TICK_TIME_MS = 1;       // Event timer unit
    localparam int unsigned INHIBIT_UNIT_MS = 100;  // Inhibit time unit
    localparam int unsigned INH_CNT_W = 23;         // Holds 65535 * 100 + 1

    // Block geometry
    localparam int unsigned NUM_TPDO = 4;
    localparam int unsigned MAP_SLOTS_DEF = 8;
    localparam int unsigned ADDR_W = 16;

    // Register indices (byte address = 4 * index)
    localparam logic [15:0] TPDO1_COMM_COUNT_IDX = 16'h1800;
    localparam logic [15:0] TPDO2_COMM_COUNT_IDX = 16'h1801;
    localparam logic [15:0] TPDO3_COMM_COUNT_IDX = 16'h1802;
    localparam logic [15:0] TPDO4_COMM_COUNT_IDX = 16'h1803;
    localparam logic [15:0] TPDO1_MAP_COUNT_IDX = 16'h1a00;
    localparam logic [15:0] COMM_BASE_IDX = 16'h2000;     // + 8 * pdo + sub
    localparam logic [15:0] MAP_SLOT_BASE_IDX = 16'h2100; // + slot (1..8)
    localparam logic [15:0] STATUS_IDX = 16'h2200;
    localparam logic [15:0] MAP_BITS_IDX = 16'h2201;

    // Communication sub-entries
    localparam logic [2:0] SUB_ID = 3'h1;
    localparam logic [2:0] SUB_TTYPE = 3'h2;
    localparam logic [2:0] SUB_INHIBIT = 3'h3;
    localparam logic [2:0] SUB_COMPAT = 3'h4;
    localparam logic [2:0] SUB_EVENT = 3'h5;
    localparam logic [7:0] COMM_ENTRIES = 8'h05;

    // Transmission type ranges
    localparam logic [7:0] TTYPE_SYNC_MIN = 8'h01;
    localparam logic [7:0] TTYPE_SYNC_MAX = 8'hf0;
    localparam logic [7:0] TTYPE_ASYNC_A = 8'hfe;
    localparam logic [7:0] TTYPE_ASYNC_B = 8'hff;

    // Mapping entry fields
    localparam int unsigned MAP_LEN_LSB = 0;
    localparam int unsigned MAP_SUB_LSB = 8;
    localparam int unsigned MAP_IDX_LSB = 16;

    // Reset values
    localparam logic [31:0] ID_RST = 32'h0000_0000;
    localparam logic [7:0] TTYPE_RST = 8'h00;
    localparam logic [31:0] MAP_SLOT1_RST = 32'h6041_0010; // Status word, 16 bits
    localparam logic [7:0] MAP_COUNT_RST = 8'h01;
endpackage

// ---- hdl/tpdo_transmit_config.sv ----
// Purpose: Transmit PDO parameters, mapping set and transmit triggering
// Assumes: Avalon-MM slave with waitrequest; sync_i and event_i are same-clock pulses
// Notes:   Triggers leave through a two-entry buffer as PDO number and identifier
//          A write lands at the edge that takes it; the answer cycle follows
// Behaviour
// - Each communication object reads five sub-entries at sub-entry zero, read only.
// - Types 1 to 240 send on every n-th SYNC, n being the type.
// - Types 254 and 255 send on internal events, not on SYNC.
// - Inhibit time, units of 100 ms, is the least gap between sends.
// - Each PDO holds a writable 16-bit event timer in ms setting the period.
// - Mapping word: length bits 0-7, sub-index 8-15, index 16-31.
// - First mapping slot defaults to the drive status word object.
// - Writable mapping count selects active slots; slots list sendable objects.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tpdo_transmit_config #(
    parameter int unsigned MS_CYCLES = tpdo_cfg_pkg::CLK_HZ /
        (tpdo_cfg_pkg::MS_PER_SEC / tpdo_cfg_pkg::TICK_TIME_MS),
    parameter int unsigned MAP_SLOTS = tpdo_cfg_pkg::MAP_SLOTS_DEF
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Async reset, active high
    input wire logic [15:0] address_i, // Word index
    input wire logic read_i, // Read request
    input wire logic write_i, // Write request
    input wire logic [31:0] writedata_i, // Write data
    input wire logic [3:0] byteenable_i, // Byte lanes
    output logic [31:0] readdata_o, // Read data
    output logic waitrequest_o, // Low for the answer cycle
    input wire logic sync_i, // SYNC received, one-cycle pulse
    input wire logic [3:0] event_i, // Internal event per PDO
    output logic tx_valid_o, // Transmit request valid
    input wire logic tx_ready_i, // Transmitter takes request
    output logic [1:0] tx_pdo_o, // PDO number, 0 is the first
    output logic [31:0] tx_cob_id_o // Identifier to send with
);
    localparam int unsigned NT = tpdo_cfg_pkg::NUM_TPDO;
    localparam int unsigned IW = tpdo_cfg_pkg::INH_CNT_W;
    localparam int unsigned TICK_W = $clog2(MS_CYCLES);
    localparam int unsigned ENTRY_W = 34;

    typedef struct packed {
        logic [NT-1:0][31:0] cob_id;
        logic [NT-1:0][7:0] ttype;
        logic [NT-1:0][15:0] inhibit;
        logic [NT-1:0][15:0] compat;
        logic [NT-1:0][15:0] evt;
        logic [NT-1:0][7:0] sync_cnt;
        logic [NT-1:0][15:0] evt_cnt;
        logic [NT-1:0][IW-1:0] inh_cnt;
        logic [NT-1:0] pend;
        logic [7:0] map_cnt;
        logic [MAP_SLOTS-1:0][31:0] map;
        logic [TICK_W-1:0] div;
        logic tick;
        logic [1:0] vld;
        logic [1:0][ENTRY_W-1:0] fifo;
        logic waitreq;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t d;
    logic [NT-1:0] hit;
    logic push;
    logic [1:0] sel;
    logic acc;
    logic [15:0] map_bits;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Mapping word field decode
    function automatic logic [7:0] map_len(input logic [31:0] m);
        return m[tpdo_cfg_pkg::MAP_LEN_LSB +: 8];
    endfunction

    function automatic logic [15:0] map_index(input logic [31:0] m);
        return m[tpdo_cfg_pkg::MAP_IDX_LSB +: 16];
    endfunction

    function automatic logic [7:0] map_sub(input logic [31:0] m);
        return m[tpdo_cfg_pkg::MAP_SUB_LSB +: 8];
    endfunction

    // Inhibit reload in ms ticks; one extra tick so the gap is never short
    function automatic logic [IW-1:0] inh_load(input logic [15:0] v);
        if (v == 16'h0000) begin
            return '0;
        end
        return IW'(v) * IW'(tpdo_cfg_pkg::INHIBIT_UNIT_MS) + IW'(1);
    endfunction

    // Next-state logic: divider, bus, triggers, inhibit, buffer
    always_comb begin
        logic [2:0] sub;
        logic [1:0] pn;
        logic [3:0] slot;
        logic comm_hit;
        logic slot_hit;
        logic [31:0] w;
        logic [ENTRY_W-1:0] entry;
        sub = address_i[2:0];
        pn = address_i[4:3];
        slot = address_i[3:0];
        comm_hit = address_i[15:5] == tpdo_cfg_pkg::COMM_BASE_IDX[15:5];
        slot_hit = address_i[15:4] == tpdo_cfg_pkg::MAP_SLOT_BASE_IDX[15:4]
            && slot != 4'h0 && 32'(slot) <= MAP_SLOTS;
        w = '0;
        entry = '0;
        d = q;
        hit = '0;
        push = 1'b0;
        sel = 2'h0;
        map_bits = '0;

        // Millisecond tick from the system clock
        d.tick = 1'b0;
        if (q.div == TICK_W'(MS_CYCLES - 1)) begin
            d.div = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 1'b1;
        end

        // Total mapped bits over the active slots only
        for (int s = 0; s < MAP_SLOTS; s++) begin
            if (32'(s) < 32'(q.map_cnt)) begin
                map_bits = map_bits + 16'(map_len(q.map[s]));
            end
        end

        // Trigger sources per PDO
        // Types 0 and 241 to 253 fall through every branch and never send
        for (int i = 0; i < NT; i++) begin
            if (sync_i && q.ttype[i] >= tpdo_cfg_pkg::TTYPE_SYNC_MIN
                && q.ttype[i] <= tpdo_cfg_pkg::TTYPE_SYNC_MAX) begin
                if (q.sync_cnt[i] + 8'h01 >= q.ttype[i]) begin
                    hit[i] = 1'b1;
                    d.sync_cnt[i] = '0;
                end else begin
                    d.sync_cnt[i] = q.sync_cnt[i] + 8'h01;
                end
            end
            if (q.ttype[i] >= tpdo_cfg_pkg::TTYPE_ASYNC_A) begin
                if (event_i[i]) begin
                    hit[i] = 1'b1;
                end
                // Zero period means no cyclic sends at all
                if (q.evt[i] == 16'h0000) begin
                    d.evt_cnt[i] = '0;
                end else if (q.tick) begin
                    if (q.evt_cnt[i] + 16'h0001 >= q.evt[i]) begin
                        hit[i] = 1'b1;
                        d.evt_cnt[i] = '0;
                    end else begin
                        d.evt_cnt[i] = q.evt_cnt[i] + 16'h0001;
                    end
                end
            end else begin
                d.evt_cnt[i] = '0;
            end
            if (q.tick && q.inh_cnt[i] != '0) begin
                d.inh_cnt[i] = q.inh_cnt[i] - IW'(1);
            end
        end

        // Lowest pending PDO whose inhibit has run out goes first
        for (int i = NT - 1; i >= 0; i--) begin
            if (q.pend[i] && q.inh_cnt[i] == '0) begin
                push = !q.vld[1];
                sel = 2'(i);
            end
        end
        if (push) begin
            d.pend[sel] = 1'b0;
            d.inh_cnt[sel] = inh_load(q.inhibit[sel]);
            d.evt_cnt[sel] = '0;
            entry = {sel, q.cob_id[sel]};
        end
        // A trigger in the cycle of the clear still stands
        d.pend = d.pend | hit;

        // Two-entry buffer; head entry drives the outputs
        // A full second entry holds back every push, so a stall drops no request
        if (q.vld[0] && tx_ready_i) begin
            d.fifo[0] = q.fifo[1];
            d.vld = {1'b0, q.vld[1]};
        end
        if (push) begin
            if (d.vld[0]) begin
                d.fifo[1] = entry;
                d.vld[1] = 1'b1;
            end else begin
                d.fifo[0] = entry;
                d.vld[0] = 1'b1;
            end
        end

        // Bus slave: one wait cycle, then the answer cycle
        // Reads and writes share one timing, so the master needs no direction case
        acc = (read_i || write_i) && q.waitreq;
        d.waitreq = !acc;
        if (acc && read_i) begin
            d.rdata = '0;
            if (address_i[15:2] == tpdo_cfg_pkg::TPDO1_COMM_COUNT_IDX[15:2]) begin
                d.rdata = 32'(tpdo_cfg_pkg::COMM_ENTRIES);
            end else if (comm_hit) begin
                case (sub)
                    tpdo_cfg_pkg::SUB_ID: d.rdata = q.cob_id[pn];
                    tpdo_cfg_pkg::SUB_TTYPE: d.rdata = 32'(q.ttype[pn]);
                    tpdo_cfg_pkg::SUB_INHIBIT: d.rdata = 32'(q.inhibit[pn]);
                    tpdo_cfg_pkg::SUB_COMPAT: d.rdata = 32'(q.compat[pn]);
                    tpdo_cfg_pkg::SUB_EVENT: d.rdata = 32'(q.evt[pn]);
                    default: d.rdata = '0;
                endcase
            end else if (address_i == tpdo_cfg_pkg::TPDO1_MAP_COUNT_IDX) begin
                d.rdata = 32'(q.map_cnt);
            end else if (slot_hit) begin
                d.rdata = q.map[slot - 4'h1];
            end else if (address_i == tpdo_cfg_pkg::STATUS_IDX) begin
                for (int i = 0; i < NT; i++) begin
                    d.rdata[i] = q.pend[i];
                    d.rdata[NT + i] = q.inh_cnt[i] != '0;
                end
            end else if (address_i == tpdo_cfg_pkg::MAP_BITS_IDX) begin
                d.rdata = 32'(map_bits);
            end
        end
        // Writes; the count register is read only and ignores them
        if (acc && write_i) begin
            if (comm_hit) begin
                case (sub)
                    tpdo_cfg_pkg::SUB_ID: begin
                        d.cob_id[pn] = merge(q.cob_id[pn], writedata_i, byteenable_i);
                    end
                    tpdo_cfg_pkg::SUB_TTYPE: begin
                        w = merge(32'(q.ttype[pn]), writedata_i, byteenable_i);
                        d.ttype[pn] = w[7:0];
                        d.sync_cnt[pn] = '0;
                    end
                    tpdo_cfg_pkg::SUB_INHIBIT: begin
                        w = merge(32'(q.inhibit[pn]), writedata_i, byteenable_i);
                        d.inhibit[pn] = w[15:0];
                    end
                    tpdo_cfg_pkg::SUB_COMPAT: begin
                        w = merge(32'(q.compat[pn]), writedata_i, byteenable_i);
                        d.compat[pn] = w[15:0];
                    end
                    tpdo_cfg_pkg::SUB_EVENT: begin
                        w = merge(32'(q.evt[pn]), writedata_i, byteenable_i);
                        d.evt[pn] = w[15:0];
                    end
                    default: d.cob_id[pn] = q.cob_id[pn];
                endcase
            end else if (address_i == tpdo_cfg_pkg::TPDO1_MAP_COUNT_IDX) begin
                w = merge(32'(q.map_cnt), writedata_i, byteenable_i);
                // Counts beyond the slot table are refused
                if (w[7:0] <= 8'(MAP_SLOTS)) begin
                    d.map_cnt = w[7:0];
                end
            end else if (slot_hit) begin
                d.map[slot - 4'h1] = merge(q.map[slot - 4'h1], writedata_i, byteenable_i);
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
            q.waitreq <= 1'b1;
            q.cob_id <= {NT{tpdo_cfg_pkg::ID_RST}};
            q.ttype <= {NT{tpdo_cfg_pkg::TTYPE_RST}};
            q.map_cnt <= tpdo_cfg_pkg::MAP_COUNT_RST;
            q.map[0] <= tpdo_cfg_pkg::MAP_SLOT1_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign readdata_o = q.rdata;
    assign waitrequest_o = q.waitreq;
    assign tx_valid_o = q.vld[0];
    assign tx_pdo_o = q.fifo[0][ENTRY_W-1 -: 2];
    assign tx_cob_id_o = q.fifo[0][31:0];

    // Checks
    a_comm_count_read: assert property (@(posedge clk_i) disable iff (reset_i)
        (read_i && waitrequest_o && address_i == tpdo_cfg_pkg::TPDO2_COMM_COUNT_IDX)
        |=> (!waitrequest_o && readdata_o == 32'(tpdo_cfg_pkg::COMM_ENTRIES)))
        else $error("Count entry did not read five");

    a_sync_trigger: assert property (@(posedge clk_i) disable iff (reset_i)
        (sync_i && q.ttype[0] == tpdo_cfg_pkg::TTYPE_SYNC_MIN) |=> q.pend[0])
        else $error("Type one did not trigger on SYNC");

    a_async_event: assert property (@(posedge clk_i) disable iff (reset_i)
        (event_i[0] && q.ttype[0] == tpdo_cfg_pkg::TTYPE_ASYNC_B) |=> q.pend[0])
        else $error("Event did not trigger asynchronous PDO");

    a_async_no_sync: assert property (@(posedge clk_i) disable iff (reset_i)
        (sync_i && q.ttype[0] >= tpdo_cfg_pkg::TTYPE_ASYNC_A && !event_i[0]
         && q.evt[0] == 16'h0000) |-> !hit[0])
        else $error("SYNC triggered an asynchronous PDO");

    a_inhibit_gap: assert property (@(posedge clk_i) disable iff (reset_i)
        (push && sel == 2'h0) |-> (q.inh_cnt[0] == '0 ##1 (q.inhibit[0] == 16'h0000
         || q.inh_cnt[0] == inh_load($past(q.inhibit[0])))))
        else $error("Inhibit window not honoured");

    a_event_timer_write: assert property (@(posedge clk_i) disable iff (reset_i)
        (write_i && waitrequest_o && byteenable_i == 4'hf
         && address_i == (tpdo_cfg_pkg::COMM_BASE_IDX | {11'h000, 2'h2, tpdo_cfg_pkg::SUB_EVENT}))
        |=> q.evt[2] == 16'($past(writedata_i)))
        else $error("Event timer write lost");

    a_map_index_field: assert property (@(posedge clk_i) disable iff (reset_i)
        (read_i && waitrequest_o && address_i == (tpdo_cfg_pkg::MAP_SLOT_BASE_IDX | 16'h0001))
        |=> (readdata_o[31:16] == map_index(q.map[0]) && readdata_o[15:8] == map_sub(q.map[0])))
        else $error("Mapping fields misplaced");

    a_status_default: assert property (@(posedge clk_i) disable iff (reset_i)
        $past(reset_i) |-> (q.map[0] == tpdo_cfg_pkg::MAP_SLOT1_RST
         && q.map_cnt == tpdo_cfg_pkg::MAP_COUNT_RST))
        else $error("First slot is not the status word");

    a_map_count_limit: assert property (@(posedge clk_i) disable iff (reset_i)
        (write_i && waitrequest_o && byteenable_i[0] && writedata_i[7:0] > 8'(MAP_SLOTS)
         && address_i == tpdo_cfg_pkg::TPDO1_MAP_COUNT_IDX) |=> $stable(q.map_cnt))
        else $error("Oversized mapping count accepted");

    a_timer_zero_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (q.evt[2] == 16'h0000 && q.ttype[2] >= tpdo_cfg_pkg::TTYPE_ASYNC_A && !event_i[2])
        |-> !hit[2])
        else $error("Zero event timer still sent");

    a_fifo_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (tx_valid_o && !tx_ready_i) |=> (tx_valid_o && $stable(tx_cob_id_o) && $stable(tx_pdo_o)))
        else $error("Stalled request changed");

    // Types between the sync range and the event range ignore SYNC
    a_gap_type_silent: assert property (@(posedge clk_i) disable iff (reset_i)
        (sync_i && q.ttype[1] > tpdo_cfg_pkg::TTYPE_SYNC_MAX
         && q.ttype[1] < tpdo_cfg_pkg::TTYPE_ASYNC_A)
        |-> !hit[1])
        else $error("Reserved type sent on SYNC");

    // A running inhibit holds back every push of that PDO
    a_inhibit_blocks: assert property (@(posedge clk_i) disable iff (reset_i)
        (q.inh_cnt[2] != '0) |-> !(push && sel == 2'h2))
        else $error("Push during inhibit");

    // A push into an empty buffer shows at the head one cycle later
    a_head_load: assert property (@(posedge clk_i) disable iff (reset_i)
        (push && !q.vld[0]) |=> (tx_valid_o && tx_pdo_o == $past(sel)))
        else $error("Pushed request missing at head");
endmodule // tpdo_transmit_config
`default_nettype wire

// ---- verif/tx_sink.sv ----
// Purpose: Transmitter model that takes requests off the transmit stream
// Assumes: Same clock as the block; a request is taken when valid and ready
// Notes:   Stall holds ready low so that the block's buffer fills up
`timescale 1ns/1ps
`default_nettype none
module tx_sink (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Async reset, active high
    input wire logic stall_i, // Hold off taking requests
    input wire logic tx_valid_i, // Request valid
    input wire logic [1:0] tx_pdo_i, // PDO number
    input wire logic [31:0] tx_cob_id_i, // Identifier
    output logic tx_ready_o, // Request taken
    output logic [15:0] taken_o, // Requests taken so far
    output logic [1:0] last_pdo_o, // PDO of the last request
    output logic [31:0] last_cob_o // Identifier of the last request
);
    // Ready is a plain level, so a stall never loses a request in flight
    assign tx_ready_o = !stall_i;
    // Record every request taken
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            taken_o <= 16'h0000;
            last_pdo_o <= 2'h0;
            last_cob_o <= 32'h0000_0000;
        end else if (tx_valid_i && tx_ready_o) begin
            taken_o <= taken_o + 16'h0001;
            last_pdo_o <= tx_pdo_i;
            last_cob_o <= tx_cob_id_i;
        end
    end
endmodule // tx_sink
`default_nettype wire

// ---- verif/tpdo_transmit_config_test.sv ----
// Purpose: Self-checking bench for the transmit PDO configuration block
// Assumes: MS_CYCLES shortened to 10 clocks per ms tick
// Notes:   Counts of sends are judged with a margin of one tick boundary
`timescale 1ns/1ps
`default_nettype none
module tpdo_transmit_config_test;
    logic clk_i, reset_i, read_i, write_i, sync_i, stall;
    logic [15:0] address_i, taken;
    logic [31:0] writedata_i, readdata_o, tx_cob_id_o, last_cob;
    logic [3:0] event_i, byteenable_i;
    logic waitrequest_o, tx_valid_o, tx_ready;
    logic [1:0] tx_pdo_o, last_pdo;
    int fail_count, n_checks;

    tpdo_transmit_config #(.MS_CYCLES(10)) tpdo_transmit_config_i (.clk_i(clk_i), .reset_i(reset_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .sync_i(sync_i),
        .event_i(event_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready), .tx_pdo_o(tx_pdo_o),
        .tx_cob_id_o(tx_cob_id_o));
    tx_sink tx_sink_i (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
        .tx_pdo_i(tx_pdo_o), .tx_cob_id_i(tx_cob_id_o), .tx_ready_o(tx_ready), .taken_o(taken),
        .last_pdo_o(last_pdo), .last_cob_o(last_cob));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = !clk_i;
    end

    task automatic stop_test;
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chkn(input string nm, input logic [15:0] seen, input int e);
        chk(nm, {16'h0000, seen}, 32'(e));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= wd;
        write_i <= w;
        read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        rd = readdata_o;
        chkn("bus answer", 16'(n >= 50), 0);
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0000_0000, d);
    endtask

    function automatic logic [15:0] ca(input logic [1:0] p, input logic [2:0] s);
        return tpdo_cfg_pkg::COMM_BASE_IDX + {11'h000, p, s};
    endfunction

    task automatic pulse(input logic s, input logic [3:0] e);
        @(posedge clk_i);
        sync_i <= s;
        event_i <= e;
        @(posedge clk_i);
        sync_i <= 1'b0;
        event_i <= 4'h0;
    endtask

    // Reset values, read-only counts, unmapped index
    task automatic t_regs;
        logic [31:0] d;
        for (int p = 0; p < 4; p++) begin
            rd(tpdo_cfg_pkg::TPDO1_COMM_COUNT_IDX + 16'(p), d);
            chk("entry count", d, 32'h0000_0005);
        end
        wr(tpdo_cfg_pkg::TPDO3_COMM_COUNT_IDX, 32'h0000_0077);
        rd(tpdo_cfg_pkg::TPDO3_COMM_COUNT_IDX, d);
        chk("entry count kept", d, 32'h0000_0005);
        rd(tpdo_cfg_pkg::MAP_SLOT_BASE_IDX + 16'h0001, d);
        chk("slot1 default", d, 32'h6041_0010);
        rd(16'h3000, d);
        chk("unmapped", d, 32'h0000_0000);
        rd(ca(2'h2, 3'h5), d);
        chk("timer reset", d, 32'h0000_0000);
    endtask

    // Mapping fields and active slot count
    task automatic t_map;
        logic [31:0] d;
        wr(tpdo_cfg_pkg::MAP_SLOT_BASE_IDX + 16'h0002, 32'h6061_2a08);
        rd(tpdo_cfg_pkg::MAP_BITS_IDX, d);
        chk("bits one slot", d, 32'h0000_0010);
        wr(tpdo_cfg_pkg::TPDO1_MAP_COUNT_IDX, 32'h0000_0002);
        rd(tpdo_cfg_pkg::MAP_BITS_IDX, d);
        chk("bits two slots", d, 32'h0000_0018);
        wr(tpdo_cfg_pkg::TPDO1_MAP_COUNT_IDX, 32'h0000_0009);
        rd(tpdo_cfg_pkg::TPDO1_MAP_COUNT_IDX, d);
        chk("map count", d, 32'h0000_0002);
        rd(tpdo_cfg_pkg::MAP_SLOT_BASE_IDX + 16'h0002, d);
        chk("slot2", d, 32'h6061_2a08);
        // Low lane only: the upper lanes of the slot are kept
        byteenable_i <= 4'h1;
        wr(tpdo_cfg_pkg::MAP_SLOT_BASE_IDX + 16'h0002, 32'hffff_ff20);
        byteenable_i <= 4'hf;
        rd(tpdo_cfg_pkg::MAP_SLOT_BASE_IDX + 16'h0002, d);
        chk("slot2 lane", d, 32'h6061_2a20);
    endtask

    // Every n-th SYNC, boundary type 240, no-send type 241
    task automatic t_sync;
        logic [15:0] n0;
        wr(ca(2'h1, 3'h1), 32'h0000_0181);
        wr(ca(2'h1, 3'h2), 32'h0000_0003);
        n0 = taken;
        repeat (8) pulse(1'b1, 4'h0);
        cyc(5);
        chkn("sync of 3", taken - n0, 2);
        chk("sync cob", last_cob, 32'h0000_0181);
        chk("sync pdo", {30'h0000_0000, last_pdo}, 32'h0000_0001);
        pulse(1'b1, 4'h2);
        cyc(5);
        chkn("ninth sync", taken - n0, 3);
        pulse(1'b0, 4'h2);
        cyc(5);
        chkn("event on sync type", taken - n0, 3);
        wr(ca(2'h1, 3'h2), 32'h0000_00f0);
        repeat (239) pulse(1'b1, 4'h0);
        cyc(5);
        chkn("239 of 240", taken - n0, 3);
        pulse(1'b1, 4'h0);
        cyc(5);
        chkn("240 of 240", taken - n0, 4);
        wr(ca(2'h1, 3'h2), 32'h0000_00f1);
        repeat (3) pulse(1'b1, 4'h2);
        cyc(5);
        chkn("type 241", taken - n0, 4);
        wr(ca(2'h0, 3'h2), 32'h0000_0001);
        repeat (2) pulse(1'b1, 4'h0);
        cyc(5);
        chkn("type 1", taken - n0, 6);
    endtask

    // Event send and 100 ms inhibit gap (1010 clocks here)
    task automatic t_event;
        logic [15:0] n0;
        wr(ca(2'h0, 3'h2), 32'h0000_00ff);
        wr(ca(2'h0, 3'h1), 32'h0000_0180);
        wr(ca(2'h0, 3'h3), 32'h0000_0001);
        n0 = taken;
        pulse(1'b1, 4'h0);
        cyc(5);
        chkn("sync on event type", taken - n0, 0);
        pulse(1'b0, 4'h1);
        cyc(5);
        chkn("event send", taken - n0, 1);
        chk("event cob", last_cob, 32'h0000_0180);
        pulse(1'b0, 4'h1);
        cyc(900);
        chkn("inhibit holds", taken - n0, 1);
        cyc(250);
        chkn("inhibit over", taken - n0, 2);
        wr(ca(2'h0, 3'h3), 32'h0000_0000);
    endtask

    // Cyclic send of 5 ms, inhibit limiting it, zero timer stopping it
    task automatic t_timer;
        logic [15:0] n0, k;
        wr(ca(2'h2, 3'h2), 32'h0000_00fe);
        wr(ca(2'h2, 3'h5), 32'h0000_0005);
        n0 = taken;
        cyc(505);
        k = taken - n0;
        chkn("timer rate", 16'(k >= 9 && k <= 11), 1);
        wr(ca(2'h2, 3'h3), 32'h0000_0001);
        n0 = taken;
        cyc(900);
        chkn("timer vs inhibit", 16'(taken - n0 <= 1), 1);
        wr(ca(2'h2, 3'h5), 32'h0000_0000);
        cyc(1100);
        n0 = taken;
        cyc(300);
        chkn("timer off", taken - n0, 0);
    endtask

    // Full two-entry buffer under stall, then drained to empty
    task automatic t_buffer;
        logic [15:0] n0;
        wr(ca(2'h3, 3'h1), 32'h0000_0183);
        wr(ca(2'h3, 3'h2), 32'h0000_00ff);
        @(posedge clk_i);
        stall <= 1'b1;
        n0 = taken;
        pulse(1'b0, 4'h9);
        cyc(4);
        pulse(1'b0, 4'h1);
        cyc(20);
        chkn("stalled", taken - n0, 0);
        chk("head valid", {31'h0000_0000, tx_valid_o}, 32'h0000_0001);
        chk("head pdo", {30'h0000_0000, tx_pdo_o}, 32'h0000_0000);
        @(posedge clk_i);
        stall <= 1'b0;
        cyc(20);
        chkn("drained", taken - n0, 3);
        chk("last cob", last_cob, 32'h0000_0180);
        chk("empty", {31'h0000_0000, tx_valid_o}, 32'h0000_0000);
    endtask

    // Watchdog well beyond the expected run of some 25 us
    initial begin
        #200_000;
        fail_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        reset_i = 1'b1;
        read_i = 1'b0;
        write_i = 1'b0;
        sync_i = 1'b0;
        stall = 1'b0;
        event_i = 4'h0;
        byteenable_i = 4'hf;
        address_i = 16'h0000;
        writedata_i = 32'h0000_0000;
        fail_count = 0;
        n_checks = 0;
        cyc(20);
        reset_i <= 1'b0;
        t_regs();
        t_map();
        t_sync();
        t_event();
        t_timer();
        t_buffer();
        stop_test();
    end
endmodule // tpdo_transmit_config_test
`default_nettype wire
